// File: design/meter_command_interpreter.v
`default_nettype none
`include "meter_cmd_consts.vh"
// Command interpreter of a resistance meter, driven over APB.
module meter_command_interpreter #(
    parameter [15:0] IDENT_CODE  = 16'h0a5a, // Arbitrary identity value
    parameter [15:0] SERIAL_NUM  = 16'h0001, // Arbitrary serial value
    parameter [15:0] VERSION_NUM = 16'h0100, // Arbitrary version value
    parameter [23:0] CAL_DATE    = 24'h010100 // dd.mm.yy packed as bytes
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire        cal_mode,
    input  wire        meas_running,
    input  wire        variant_high_amp,
    input  wire [15:0] cal_counter,
    input  wire [7:0]  oper_set,
    input  wire [7:0]  ques_set,
    output reg  [6:0]  avg_count,
    output reg         auto_emf,
    output reg         current_high,
    output reg  [3:0]  program_sel,
    output reg         zero_start,
    output wire        irq
);
    // ------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------
    wire        setup_ph = psel & ~penable;    // Setup cycle
    wire        acc_done = psel & penable;     // Access completes now
    wire        wr_acc   = acc_done & pwrite;  // Write takes effect
    wire        rd_acc   = acc_done & ~pwrite; // Read completes
    wire        mapped;                         // Address is a register

    assign pready = 1'b1;
    assign mapped = (paddr == `ADDR_CMD) || (paddr == `ADDR_RESP) ||
                    (paddr == `ADDR_SETTINGS) || (paddr == `ADDR_IRQ_STAT) ||
                    (paddr == `ADDR_IRQ_MASK) || (paddr == `ADDR_ERR) ||
                    (paddr == `ADDR_OPER_EV) || (paddr == `ADDR_QUES_EV);

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    reg  [7:0]  sre_q;          // Service request enable
    reg  [7:0]  ese_q;          // Event status enable
    reg  [7:0]  esr_q;          // Standard event status
    reg  [7:0]  oper_q;         // Operation status event
    reg  [7:0]  ques_q;         // Questionable status event
    reg  [15:0] resp_q;         // Last query answer
    reg  [3:0]  irq_stat_q;     // Sticky interrupt events
    reg  [3:0]  irq_mask_q;     // Interrupt enables
    reg  [3:0]  irq_ev;         // Events of this cycle
    reg  [7:0]  esr_ev;         // Event status bits set now
    reg         err_push;       // Log an error now
    reg  [7:0]  err_code;       // Code to log
    wire [7:0]  err_head;       // Oldest error
    wire [2:0]  err_count;      // Errors held
    wire [7:0]  stb;            // Computed status byte
    wire        cmd_wr = wr_acc & (paddr == `ADDR_CMD);
    wire [7:0]  op     = pwdata[7:0];
    wire [7:0]  arg    = pwdata[15:8];
    wire        cls_now = cmd_wr & (op == `OP_CLS);
    wire        err_pop = rd_acc & (paddr == `ADDR_ERR);

    // ------------------------------------------------------------
    // Status byte
    // ------------------------------------------------------------
    assign stb[1:0]       = 2'b00;
    assign stb[`STB_EAV]  = (err_count != 3'd0);
    assign stb[4:3]       = 2'b00;
    assign stb[`STB_ESB]  = |(esr_q & ese_q);
    assign stb[`STB_MSS]  = |({2'b00, stb[`STB_ESB], 2'b00, stb[`STB_EAV], 2'b00} & sre_q);
    assign stb[7]         = 1'b0;

    // ------------------------------------------------------------
    // Command decode: one command per CMD write, fully done in one cycle
    // ------------------------------------------------------------
    always @* begin
        irq_ev   = 4'h0;
        esr_ev   = 8'h00;
        err_push = 1'b0;
        err_code = 8'h00;
        if (cmd_wr) begin
            irq_ev[`IRQ_ACK] = 1'b1;
            case (op)
                `OP_AVG_SET: begin
                    if (cal_mode || meas_running) begin
                        irq_ev[`IRQ_REFUSED] = 1'b1;
                        esr_ev[`ESR_EXE]     = 1'b1;
                        err_push             = 1'b1;
                        err_code             = `ERR_CONFLICT;
                    end else if (arg < `AVG_MIN || arg > `AVG_MAX) begin
                        irq_ev[`IRQ_PARAM] = 1'b1;
                        esr_ev[`ESR_EXE]   = 1'b1;
                        err_push           = 1'b1;
                        err_code           = `ERR_RANGE;
                    end
                end
                `OP_AUTO_SET: begin
                    if (cal_mode || meas_running) begin
                        irq_ev[`IRQ_REFUSED] = 1'b1;
                        esr_ev[`ESR_EXE]     = 1'b1;
                        err_push             = 1'b1;
                        err_code             = `ERR_CONFLICT;
                    end else if (arg > 8'h01) begin
                        irq_ev[`IRQ_PARAM] = 1'b1;
                        esr_ev[`ESR_EXE]   = 1'b1;
                        err_push           = 1'b1;
                        err_code           = `ERR_RANGE;
                    end
                end
                `OP_ZERO: begin
                    if (cal_mode) begin
                        irq_ev[`IRQ_REFUSED] = 1'b1;
                        esr_ev[`ESR_EXE]     = 1'b1;
                        err_push             = 1'b1;
                        err_code             = `ERR_CONFLICT;
                    end else begin
                        irq_ev[`IRQ_ZERO] = 1'b1;
                    end
                end
                `OP_CURR_SET: begin
                    if (cal_mode) begin
                        irq_ev[`IRQ_REFUSED] = 1'b1;
                        esr_ev[`ESR_EXE]     = 1'b1;
                        err_push             = 1'b1;
                        err_code             = `ERR_CONFLICT;
                    end else if (arg > 8'h01) begin
                        irq_ev[`IRQ_PARAM] = 1'b1;
                        esr_ev[`ESR_EXE]   = 1'b1;
                        err_push           = 1'b1;
                        err_code           = `ERR_RANGE;
                    end
                end
                `OP_RCL_SET: begin
                    if (arg > `PROG_MAX) begin
                        irq_ev[`IRQ_PARAM] = 1'b1;
                        esr_ev[`ESR_EXE]   = 1'b1;
                        err_push           = 1'b1;
                        err_code           = `ERR_RANGE;
                    end
                end
                // Accepted opcodes with no error path
                `OP_AVG_QRY, `OP_AUTO_QRY, `OP_CURR_QRY, `OP_SRE_SET,
                `OP_SRE_QRY, `OP_STB_QRY, `OP_ESE_SET, `OP_ESE_QRY,
                `OP_ESR_QRY, `OP_OPC, `OP_RST, `OP_TST_QRY, `OP_WAI,
                `OP_CLS, `OP_IDN_QRY, `OP_RCL_QRY: begin
                    err_push = 1'b0;
                end
                // Unknown command header
                default: begin
                    irq_ev[`IRQ_REFUSED] = 1'b1;
                    esr_ev[`ESR_CMD]     = 1'b1;
                    err_push             = 1'b1;
                    err_code             = `ERR_UNDEF_HDR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Error buffer
    // ------------------------------------------------------------
    error_buffer u_err (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .push      (err_push),
        .push_code (err_code),
        .pop       (err_pop),
        .clear     (cls_now),
        .head_code (err_head),
        .count     (err_count)
    );

    // ------------------------------------------------------------
    // Measurement settings
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            avg_count    <= `AVG_RST;
            auto_emf     <= `AUTO_RST;
            current_high <= `CURR_RST;
            program_sel  <= `PROG_RST;
        end else if (cmd_wr && op == `OP_RST) begin
            avg_count    <= `AVG_RST;
            auto_emf     <= `AUTO_RST;
            current_high <= `CURR_RST;
            program_sel  <= `PROG_RST;
        end else if (cmd_wr && !irq_ev[`IRQ_REFUSED] && !irq_ev[`IRQ_PARAM]) begin
            case (op)
                `OP_AVG_SET:  avg_count    <= arg[6:0];
                `OP_AUTO_SET: auto_emf     <= arg[0];
                `OP_CURR_SET: current_high <= arg[0];
                `OP_RCL_SET:  program_sel  <= arg[3:0];
                default:      program_sel  <= program_sel;
            endcase
        end
    end

    // Zero-offset start pulse, one cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            zero_start <= 1'b0;
        end else begin
            zero_start <= irq_ev[`IRQ_ZERO];
        end
    end

    // ------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            sre_q <= 8'h00;
            ese_q <= 8'h00;
        end else if (cmd_wr) begin
            if (op == `OP_SRE_SET) sre_q <= arg;
            if (op == `OP_ESE_SET) ese_q <= arg;
        end
    end

    // ------------------------------------------------------------
    // Event registers: set wins over clear
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            esr_q  <= 8'h00;
            oper_q <= 8'h00;
            ques_q <= 8'h00;
        end else begin
            // Event status cleared by clear or by being read out
            if (cls_now || (cmd_wr && op == `OP_ESR_QRY)) begin
                esr_q <= esr_ev;
            end else begin
                esr_q <= esr_q | esr_ev;
            end
            oper_q <= (cls_now ? 8'h00 : oper_q) | oper_set;
            ques_q <= (cls_now ? 8'h00 : ques_q) | ques_set;
        end
    end

    // ------------------------------------------------------------
    // Query answers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            resp_q <= 16'h0000;
        end else if (cmd_wr) begin
            case (op)
                `OP_AVG_QRY:  resp_q <= {9'h000, avg_count};
                `OP_AUTO_QRY: resp_q <= {15'h0000, auto_emf};
                `OP_CURR_QRY: resp_q <= current_high ? `CURR_KW_MAX
                                                     : `CURR_KW_MIN;
                `OP_SRE_QRY:  resp_q <= {8'h00, sre_q};
                `OP_STB_QRY:  resp_q <= {8'h00, stb};
                `OP_ESE_QRY:  resp_q <= {8'h00, ese_q};
                `OP_ESR_QRY:  resp_q <= {8'h00, esr_q};
                `OP_TST_QRY:  resp_q <= `TST_ANSWER;
                `OP_RCL_QRY:  resp_q <= {12'h000, program_sel};
                `OP_IDN_QRY: begin
                    // Field chosen by parameter, in answer order
                    case (arg)
                        8'h00:   resp_q <= IDENT_CODE;
                        8'h01:   resp_q <= {15'h0000, variant_high_amp};
                        8'h02:   resp_q <= SERIAL_NUM;
                        8'h03:   resp_q <= VERSION_NUM;
                        8'h04:   resp_q <= CAL_DATE[23:8];
                        8'h05:   resp_q <= cal_counter;
                        8'h06:   resp_q <= {8'h00, CAL_DATE[7:0]};
                        default: resp_q <= 16'h0000;
                    endcase
                end
                // OPC and WAI are recognised and leave the answer untouched
                default:      resp_q <= resp_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
        end else begin
            if (wr_acc && paddr == `ADDR_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[3:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
            if (wr_acc && paddr == `ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[3:0];
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // Read data and error, captured in the setup cycle
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= ~mapped;
            prdata  <= 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `ADDR_RESP:     prdata <= {16'h0000, resp_q};
                    `ADDR_SETTINGS: prdata <= {16'h0000, program_sel, 2'b00,
                                               current_high, auto_emf,
                                               1'b0, avg_count};
                    `ADDR_IRQ_STAT: prdata <= {28'h0000000, irq_stat_q};
                    `ADDR_IRQ_MASK: prdata <= {28'h0000000, irq_mask_q};
                    `ADDR_ERR:      prdata <= {13'h0000, err_count, 8'h00,
                                               err_head};
                    `ADDR_OPER_EV:  prdata <= {24'h000000, oper_q};
                    `ADDR_QUES_EV:  prdata <= {24'h000000, ques_q};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // meter_command_interpreter
`default_nettype wire

// File: inc/meter_cmd_consts.vh
`ifndef METER_CMD_CONSTS_VH
`define METER_CMD_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADDR_CMD        12'h000
`define ADDR_RESP       12'h004
`define ADDR_SETTINGS   12'h008
`define ADDR_IRQ_STAT   12'h00c
`define ADDR_IRQ_MASK   12'h010
`define ADDR_ERR        12'h014
`define ADDR_OPER_EV    12'h018
`define ADDR_QUES_EV    12'h01c
// ----------------------------------------------------------------
// Command opcodes (CMD[7:0]); parameter in CMD[15:8]
// ----------------------------------------------------------------
`define OP_AVG_SET      8'h00
`define OP_AVG_QRY      8'h01
`define OP_ZERO         8'h02
`define OP_AUTO_SET     8'h03
`define OP_AUTO_QRY     8'h04
`define OP_CURR_SET     8'h05
`define OP_CURR_QRY     8'h06
`define OP_SRE_SET      8'h07
`define OP_SRE_QRY      8'h08
`define OP_STB_QRY      8'h09
`define OP_ESE_SET      8'h0a
`define OP_ESE_QRY      8'h0b
`define OP_ESR_QRY      8'h0c
`define OP_OPC          8'h0d
`define OP_RST          8'h0e
`define OP_TST_QRY      8'h0f
`define OP_WAI          8'h10
`define OP_CLS          8'h11
`define OP_IDN_QRY      8'h12
`define OP_RCL_SET      8'h13
`define OP_RCL_QRY      8'h14
// ----------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------
`define AVG_MIN         8'h01
`define AVG_MAX         8'h63
`define PROG_MAX        8'h0f
`define AVG_RST         7'h01
`define AUTO_RST        1'b1
`define CURR_RST        1'b0
`define PROG_RST        4'h0
`define TST_ANSWER      16'h0001
`define CURR_KW_MIN     16'h0000
`define CURR_KW_MAX     16'h0001
// ----------------------------------------------------------------
// Event status, status byte and interrupt bits
// ----------------------------------------------------------------
`define ESR_OPC         0
`define ESR_EXE         4
`define ESR_CMD         5
`define STB_EAV         2
`define STB_ESB         5
`define STB_MSS         6
`define IRQ_ACK         0
`define IRQ_REFUSED     1
`define IRQ_PARAM       2
`define IRQ_ZERO        3
// ----------------------------------------------------------------
// Error codes pushed into the error buffer, and buffer size
// ----------------------------------------------------------------
`define ERR_UNDEF_HDR   8'h01
`define ERR_CONFLICT    8'h02
`define ERR_RANGE       8'h03
`define ERR_DEPTH       4
`define ERR_AW          2
`endif

// File: design/error_buffer.v
`default_nettype none
`include "meter_cmd_consts.vh"
// Error buffer: oldest-first queue of error codes in flip-flops.
// A push into a full buffer drops the new entry.
module error_buffer (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       push,
    input  wire [7:0] push_code,
    input  wire       pop,
    input  wire       clear,
    output wire [7:0] head_code,
    output wire [2:0] count
);
    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    reg  [7:0]           mem_q [0:`ERR_DEPTH-1]; // Entries
    reg  [`ERR_AW-1:0]   wr_q;                   // Write index
    reg  [`ERR_AW-1:0]   rd_q;                   // Read index
    reg  [2:0]           cnt_q;                  // Fill level
    wire                 full  = (cnt_q == 3'd4);
    wire                 empty = (cnt_q == 3'd0);
    wire                 do_push = push & ~full;
    wire                 do_pop  = pop & ~empty;
    genvar               i;

    // Entry registers, one per slot
    generate
        for (i = 0; i < `ERR_DEPTH; i = i + 1) begin : g_slot
            always @(posedge clk) begin
                if (sys_rst) begin
                    mem_q[i] <= 8'h00;
                end else if (do_push && (wr_q == i)) begin
                    mem_q[i] <= push_code;
                end
            end
        end
    endgenerate

    // Pointers; clear empties the buffer
    always @(posedge clk) begin
        if (sys_rst || clear) begin
            wr_q  <= {`ERR_AW{1'b0}};
            rd_q  <= {`ERR_AW{1'b0}};
            cnt_q <= 3'd0;
        end else begin
            if (do_push) wr_q <= wr_q + 1'b1;
            if (do_pop)  rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + {2'b00, do_push} - {2'b00, do_pop};
        end
    end

    assign head_code = empty ? 8'h00 : mem_q[rd_q];
    assign count     = cnt_q;
endmodule // error_buffer
`default_nettype wire

// File: verif/cmd_checker_assertions.sv
`default_nettype none
`include "meter_cmd_consts.vh"
// ----------------------------------------
// Command checker
// ----------------------------------------
module cmd_checker (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        cal_mode,
    input wire logic        meas_running,
    input wire logic [6:0]  avg_count,
    input wire logic        auto_emf,
    input wire logic        current_high,
    input wire logic [3:0]  program_sel,
    input wire logic        zero_start
);
    timeunit 1ns;
    timeprecision 1ns;
    // Command write edge, its fields and permission levels
    wire logic       wr = psel & penable & pwrite & (paddr == `ADDR_CMD);
    wire logic [7:0] op = pwdata[7:0];
    wire logic [7:0] pm = pwdata[15:8];
    wire logic       ok = wr & ~cal_mode;
    wire logic       fr = ok & ~meas_running;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Start pulse lasts exactly one cycle
    sequence s_zero; zero_start ##1 !zero_start; endsequence
    a_avg_taken: assert property (fr && op == `OP_AVG_SET && pm inside {[1:99]}
        |=> {1'b0, avg_count} == $past(pm)) else $error("avg count not taken");
    a_avg_kept: assert property (wr && op == `OP_AVG_SET && !(fr && pm inside {[1:99]})
        |=> $stable(avg_count)) else $error("avg count changed");
    a_auto_taken: assert property (fr && op == `OP_AUTO_SET && pm <= 8'd1
        |=> {7'h00, auto_emf} == $past(pm)) else $error("auto state not taken");
    a_auto_kept: assert property (wr && op == `OP_AUTO_SET && !fr
        |=> $stable(auto_emf)) else $error("auto state changed");
    a_curr_taken: assert property (ok && op == `OP_CURR_SET && pm <= 8'd1
        |=> {7'h00, current_high} == $past(pm)) else $error("current not taken");
    a_zero_pulse: assert property (ok && op == `OP_ZERO |=> s_zero)
        else $error("zero start pulse wrong");
    a_rcl_taken: assert property (wr && op == `OP_RCL_SET && pm <= 8'd15
        |=> {4'h0, program_sel} == $past(pm)) else $error("program not taken");
    a_rst_state: assert property (wr && op == `OP_RST |=> avg_count == 7'd1 && auto_emf
        && !current_high && program_sel == 4'h0) else $error("reset state wrong");
endmodule // cmd_checker
bind meter_command_interpreter cmd_checker cmd_checker_i (.*);
`default_nettype wire

// File: verif/host_model.sv
`default_nettype none
`include "meter_cmd_consts.vh"
// ----------------------------------------
// Host side: APB master issuing commands
// ----------------------------------------
module host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // One transfer: setup, access until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        r = prdata;
        if (n >= 64)
            meter_command_interpreter_tb.timeout();
        // Released address and data lines show the inverse of the last value; psel and penable go low
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
    endtask
    // A whole command goes in one word, never split
    task automatic cmd(input logic [7:0] o, input logic [7:0] p);
        logic [31:0] r;
        xfer(1'b1, `ADDR_CMD, {16'h0000, p, o}, r);
    endtask
endmodule // host_model
`default_nettype wire

// File: verif/meter_command_interpreter_tb.sv
`default_nettype none
`include "meter_cmd_consts.vh"
module meter_command_interpreter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, sys_rst = 1'b1, cal_mode = 1'b0, meas_running = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, auto_emf, current_high, zero_start, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  avg_count;
    logic [3:0]  program_sel;
    logic        variant_high_amp = 1'b1;
    logic [15:0] cal_counter = 16'h2a5c;
    logic [7:0]  oper_set = 8'h00, ques_set = 8'h00;
    int          num_errors = 0, checks = 0;
    host_model host_model_i (.*);
    meter_command_interpreter meter_command_interpreter_i (.*);
    always #25 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write a register, command, query, settings snapshot
    task w(input logic [11:0] a, input logic [31:0] d);
        host_model_i.xfer(1'b1, a, d, rd);
        @(negedge clk);
    endtask
    task c(input logic [7:0] o, input logic [7:0] p);
        host_model_i.cmd(o, p);
        @(negedge clk);
    endtask
    task q(input logic [7:0] o, input logic [15:0] e);
        c(o, 8'h00);
        host_model_i.xfer(1'b0, `ADDR_RESP, 32'h0, rd);
        chk({16'h0000, rd[15:0]}, {16'h0000, e});
    endtask
    task s(input logic [12:0] e);
        chk({19'h0, avg_count, auto_emf, current_high, program_sel}, {19'h0, e});
    endtask
    task t_avg;
        c(`OP_AVG_SET, 8'd1);
        q(`OP_AVG_QRY, 16'd1);
        c(`OP_AVG_SET, 8'd99);
        c(`OP_AVG_SET, 8'd0);
        c(`OP_AVG_SET, 8'd100);
        q(`OP_AVG_QRY, 16'd99);
        $display("t_avg done");
    endtask
    task t_block;
        @(posedge clk) cal_mode <= 1'b1;
        c(`OP_AVG_SET, 8'd5);
        c(`OP_AUTO_SET, 8'd0);
        c(`OP_CURR_SET, 8'd1);
        c(`OP_ZERO, 8'h00);
        s({7'd99, 2'b10, 4'h0});
        @(posedge clk) {cal_mode, meas_running} <= 2'b01;
        c(`OP_AVG_SET, 8'd5);
        c(`OP_AUTO_SET, 8'd0);
        c(`OP_CURR_SET, 8'd1);
        s({7'd99, 2'b11, 4'h0});
        @(posedge clk) meas_running <= 1'b0;
        c(`OP_ZERO, 8'h00);
        chk({31'h0, zero_start}, 32'h1);
        $display("t_block done");
    endtask
    task t_modes;
        for (int i = 0; i < 2; i++) begin
            c(`OP_AUTO_SET, 8'(i));
            q(`OP_AUTO_QRY, 16'(i));
            c(`OP_CURR_SET, 8'(i));
            q(`OP_CURR_QRY, 16'(i));
        end
        c(`OP_RCL_SET, 8'd15);
        c(`OP_RCL_SET, 8'd16);
        q(`OP_RCL_QRY, 16'd15);
        $display("t_modes done");
    endtask
    task t_ieee;
        c(`OP_CLS, 8'h00);
        for (int i = 0; i < 2; i++) begin
            c(`OP_SRE_SET, 8'(255 - 255 * i));
            q(`OP_SRE_QRY, 16'(255 - 255 * i));
            c(`OP_ESE_SET, 8'(255 - 255 * i));
            q(`OP_ESE_QRY, 16'(255 - 255 * i));
        end
        q(`OP_TST_QRY, `TST_ANSWER);
        c(`OP_OPC, 8'h00);
        c(`OP_WAI, 8'h00);
        s({7'd99, 2'b11, 4'hf});
        c(`OP_ESE_SET, 8'h20);
        c(`OP_SRE_SET, 8'h20);
        c(8'h7f, 8'h00);
        q(`OP_STB_QRY, 16'h0064);
        q(`OP_ESR_QRY, 16'h0020);
        c(`OP_CLS, 8'h00);
        q(`OP_STB_QRY, 16'h0000);
        host_model_i.xfer(1'b0, `ADDR_ERR, 32'h0, rd);
        chk(rd, 32'h0);
        $display("t_ieee done");
    endtask
    task t_irq;
        w(`ADDR_IRQ_STAT, 32'hf);
        w(`ADDR_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h0);
        c(`OP_WAI, 8'h00);
        chk({31'h0, irq}, 32'h1);
        w(`ADDR_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        w(`ADDR_IRQ_STAT, 32'hf);
        host_model_i.xfer(1'b0, `ADDR_IRQ_STAT, 32'h0, rd);
        chk(rd, 32'h0);
        host_model_i.xfer(1'b0, 12'h020, 32'h0, rd);
        @(negedge clk);
        chk({pslverr, rd[30:0]}, 32'h80000000);
        c(`OP_AVG_SET, 8'd7);
        c(`OP_RST, 8'h00);
        s({7'd1, 2'b10, 4'h0});
        $display("t_irq done");
    endtask
    task t_stat;
        c(`OP_IDN_QRY, 8'h01);
        host_model_i.xfer(1'b0, `ADDR_RESP, 32'h0, rd);
        chk(rd, 32'h1);
        c(`OP_IDN_QRY, 8'h05);
        host_model_i.xfer(1'b0, `ADDR_RESP, 32'h0, rd);
        chk(rd, 32'h2a5c);
        @(posedge clk) {oper_set, ques_set} <= 16'h8001;
        @(posedge clk) {oper_set, ques_set} <= 16'h0000;
        host_model_i.xfer(1'b0, `ADDR_QUES_EV, 32'h0, rd);
        chk(rd, 32'h1);
        c(8'h7f, 8'h00);
        host_model_i.xfer(1'b0, `ADDR_ERR, 32'h0, rd);
        chk(rd, 32'h10001);
        c(`OP_CLS, 8'h00);
        host_model_i.xfer(1'b0, `ADDR_OPER_EV, 32'h0, rd);
        chk(rd, 32'h0);
        host_model_i.xfer(1'b0, `ADDR_SETTINGS, 32'h0, rd);
        chk(rd, 32'h101);
        $display("t_stat done");
    endtask
    task conclude;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task timeout;
        num_errors++;
        conclude;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        s({7'd1, 2'b10, 4'h0});
        t_avg;
        t_block;
        t_modes;
        t_ieee;
        t_irq;
        t_stat;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk);
        timeout;
    end
endmodule // meter_command_interpreter_tb
`default_nettype wire
